// *** verilog/clk_switch_ctrl.v ***
// Controller that moves the CPU clock of an attached device between sources.
// Assumes the device pins come from another domain and software is on mclk.
//
// Contract
// RULE_01: Main crystal needs mode 1, external select 0, main stop 0 before selection.
// RULE_02: Switch to a crystal only once stable and its stabilization time elapsed.
// RULE_03: External main clock needs mode 1, external select 1, main stop 0.
// RULE_04: Sub crystal needs sub mode 1, sub external select 0, sub stop 0.
// RULE_05: Switch to sub crystal only once its oscillation is stable.
// RULE_06: External sub clock needs sub mode 1, sub external select 1, stop 0.
// RULE_07: Fast on-chip oscillator needs stop 0 and accuracy time elapsed first.
// RULE_08: Stop fast on-chip oscillator only after CPU is confirmed on another source.
// RULE_09: Stop main crystal only after CPU clock has confirmed leaving it.
// RULE_10: Disable external main input only after CPU clock confirmed leaving it.
// RULE_11: Direct change between main crystal and external main clock is refused.
// RULE_12: Device reports the current CPU source; used to confirm every switch.
`timescale 1ns/10ps
`default_nettype none
`include "clk_switch_consts.vh"

module clk_switch_ctrl #(
  parameter XTAL_STAB_CYCLES = `XTAL_STAB_CYC
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire [2:0] cur_src_pin,
  input wire main_osc_stable,
  input wire sub_osc_stable,
  output reg [2:0] cpu_src_sel,
  output reg main_osc_mode_select,
  output reg main_external_input_select,
  output reg main_clock_stop,
  output reg sub_osc_mode_select,
  output reg sub_external_input_select,
  output reg sub_clock_stop,
  output reg onchip_fast_osc_stop
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ENABLE = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_SWITCH = 3'h3;
  localparam [2:0] S_CONFIRM = 3'h4;
  localparam [2:0] S_STOP_OLD = 3'h5;

  // Counts are cut to the timer width on purpose; a stabilization wait
  // above 65535 cycles needs a wider timer.
  localparam [31:0] XTAL_FULL = XTAL_STAB_CYCLES;
  localparam [31:0] FAST_FULL = `FAST_ACC_CYC;
  localparam [31:0] CONF_FULL = `CONFIRM_CYC;
  localparam [`TIMER_W-1:0] XTAL_CNT = XTAL_FULL[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] FAST_CNT = FAST_FULL[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] CONF_CNT = CONF_FULL[`TIMER_W-1:0];

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  wire [4:0] pin_in = {sub_osc_stable, main_osc_stable, cur_src_pin};
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  wire main_stable = sync2_q[3];
  wire sub_stable = sync2_q[4];

  // ========================================================================
  // Source report filter
  // ========================================================================
  // The source code crosses as three separately synchronised bits, so a
  // skewed change could show a false code for a cycle; a new code is only
  // taken once two successive synchronised samples agree.
  reg [2:0] cur_last_q;
  reg [2:0] cur_src_q;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cur_last_q <= `SRC_FAST;
      cur_src_q <= `SRC_FAST;
    end else begin
      cur_last_q <= sync2_q[2:0];
      if (sync2_q[2:0] == cur_last_q) begin
        cur_src_q <= cur_last_q;
      end
    end
  end
  wire [2:0] cur_src = cur_src_q;

  // ========================================================================
  // Control state
  // ========================================================================
  reg [2:0] state_q;
  reg [2:0] target_q;
  reg [2:0] prev_q;
  reg auto_stop_q;
  reg done_q;
  reg err_refused_q;
  reg err_timeout_q;
  reg err_unstable_q;
  reg tmr_load;
  reg [`TIMER_W-1:0] tmr_count;
  wire tmr_expired;

  wire busy = (state_q != S_IDLE);
  wire cmd_wr = wr_stb && (addr == `REG_CMD);
  wire flags_wr = wr_stb && (addr == `REG_FLAGS);
  wire [2:0] cmd_target = wdata[`CMD_TARGET_LSB+2:`CMD_TARGET_LSB];

  function is_main;
    input [2:0] s;
    begin
      is_main = (s == `SRC_MAIN_XTAL) || (s == `SRC_MAIN_EXT);
    end
  endfunction

  function is_sub;
    input [2:0] s;
    begin
      is_sub = (s == `SRC_SUB_XTAL) || (s == `SRC_SUB_EXT);
    end
  endfunction

  // The main pair shares one input configuration, so no direct hop.
  wire cmd_bad = (cmd_target > `SRC_SUB_EXT) ||
                 (is_main(cmd_target) && is_main(cpu_src_sel) &&
                  cmd_target != cpu_src_sel); // RULE_11

  // A family is in use while either the report or the selection points at
  // it; its stop bit is then left alone.
  wire fast_in_use = (cur_src == `SRC_FAST) || (cpu_src_sel == `SRC_FAST);
  wire main_in_use = is_main(cur_src) || is_main(cpu_src_sel);
  wire sub_in_use = is_sub(cur_src) || is_sub(cpu_src_sel);

  wait_timer u_timer (
    .mclk(mclk),
    .resetn(resetn),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_expired)
  );

  // ========================================================================
  // Sequencer
  // ========================================================================
  // The timer is loaded on entry to the wait and to the confirm, so a report
  // that never follows the request ends in a timeout rather than a hang.
  always @* begin
    tmr_load = 1'b0;
    tmr_count = CONF_CNT;
    case (state_q)
      S_ENABLE: begin
        tmr_load = 1'b1;
        if (target_q == `SRC_MAIN_XTAL || target_q == `SRC_SUB_XTAL) begin
          tmr_count = XTAL_CNT; // RULE_02
        end else if (target_q == `SRC_FAST) begin
          tmr_count = FAST_CNT; // RULE_07
        end else begin
          tmr_count = {{(`TIMER_W-1){1'b0}}, 1'b1};
        end
      end
      S_SWITCH: begin
        tmr_load = 1'b1;
        tmr_count = CONF_CNT;
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      target_q <= `SRC_FAST;
      prev_q <= `SRC_FAST;
      auto_stop_q <= 1'b0;
      done_q <= 1'b0;
      err_refused_q <= 1'b0;
      err_timeout_q <= 1'b0;
      err_unstable_q <= 1'b0;
      cpu_src_sel <= `SRC_FAST;
      main_osc_mode_select <= 1'b0;
      main_external_input_select <= 1'b0;
      main_clock_stop <= `RST_MAIN_STOP;
      sub_osc_mode_select <= 1'b0;
      sub_external_input_select <= 1'b0;
      sub_clock_stop <= `RST_SUB_STOP;
      onchip_fast_osc_stop <= `RST_FAST_STOP;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_wr) begin
            done_q <= 1'b0;
            err_timeout_q <= 1'b0;
            err_unstable_q <= 1'b0;
            if (cmd_bad) begin
              err_refused_q <= 1'b1;
            end else begin
              err_refused_q <= 1'b0;
              target_q <= cmd_target;
              prev_q <= cpu_src_sel;
              auto_stop_q <= wdata[`CMD_AUTO_STOP];
              state_q <= S_ENABLE;
            end
          end else if (flags_wr) begin
            // Only a source that the CPU is confirmed not to run on is stopped.
            if (wdata[`FL_FAST_STOP] && !fast_in_use) begin
              onchip_fast_osc_stop <= 1'b1; // RULE_08
            end
            if (wdata[`FL_MAIN_STOP] && !main_in_use) begin
              main_clock_stop <= 1'b1; // RULE_09 RULE_10
            end
            if (wdata[`FL_SUB_STOP] && !sub_in_use) begin
              sub_clock_stop <= 1'b1;
            end
          end
        end
        S_ENABLE: begin
          case (target_q)
            `SRC_FAST: begin
              onchip_fast_osc_stop <= 1'b0; // RULE_07
            end
            `SRC_MAIN_XTAL: begin
              main_osc_mode_select <= 1'b1; // RULE_01
              main_external_input_select <= 1'b0;
              main_clock_stop <= 1'b0;
            end
            `SRC_MAIN_EXT: begin
              main_osc_mode_select <= 1'b1; // RULE_03
              main_external_input_select <= 1'b1;
              main_clock_stop <= 1'b0;
            end
            `SRC_SUB_XTAL: begin
              sub_osc_mode_select <= 1'b1; // RULE_04
              sub_external_input_select <= 1'b0;
              sub_clock_stop <= 1'b0;
            end
            default: begin
              sub_osc_mode_select <= 1'b1; // RULE_06
              sub_external_input_select <= 1'b1;
              sub_clock_stop <= 1'b0;
            end
          endcase
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          // Stability is sampled once at the end of the wait; a later loss is
          // left to the confirm timeout.
          if (tmr_expired) begin
            if (target_q == `SRC_MAIN_XTAL && !main_stable) begin
              err_unstable_q <= 1'b1; // RULE_02
              state_q <= S_IDLE;
            end else if (target_q == `SRC_SUB_XTAL && !sub_stable) begin
              err_unstable_q <= 1'b1; // RULE_05
              state_q <= S_IDLE;
            end else begin
              state_q <= S_SWITCH;
            end
          end
        end
        S_SWITCH: begin
          cpu_src_sel <= target_q;
          state_q <= S_CONFIRM;
        end
        S_CONFIRM: begin
          if (cur_src == target_q) begin
            state_q <= auto_stop_q ? S_STOP_OLD : S_IDLE; // RULE_12
            done_q <= !auto_stop_q;
          end else if (tmr_expired) begin
            err_timeout_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_STOP_OLD: begin
          // The previous source is stopped only after the switch is confirmed.
          if (prev_q == `SRC_FAST && target_q != `SRC_FAST) begin
            onchip_fast_osc_stop <= 1'b1; // RULE_08
          end else if (is_main(prev_q) && !is_main(target_q)) begin
            main_clock_stop <= 1'b1; // RULE_09 RULE_10
          end else if (is_sub(prev_q) && !is_sub(target_q)) begin
            sub_clock_stop <= 1'b1;
          end
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
      // A command written while a switch runs is dropped and flagged.
      if (busy && cmd_wr) begin
        err_refused_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Read port
  // ========================================================================
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
    end else if (rd_stb) begin
      case (addr)
        `REG_CMD: begin
          rdata <= {28'h0000000, auto_stop_q, target_q};
        end
        `REG_STATUS: begin
          rdata <= {13'h0000, cpu_src_sel, 5'h00, cur_src, 3'h0,
                    err_unstable_q, err_timeout_q, err_refused_q, done_q, busy}; // RULE_12
        end
        `REG_FLAGS: begin
          rdata <= {24'h000000, sub_external_input_select, sub_osc_mode_select,
                    main_external_input_select, main_osc_mode_select, 1'b0,
                    sub_clock_stop, main_clock_stop, onchip_fast_osc_stop};
        end
        default: begin
          rdata <= 32'h00000000;
        end
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// *** verilog/clk_switch_consts.vh ***
// Constants for the CPU clock source switch controller.
// Assumes a 100 MHz controller clock and an 8-bit software address.
`ifndef CLK_SWITCH_CONSTS_VH
`define CLK_SWITCH_CONSTS_VH

// ==========================================================================
// Software register offsets
// ==========================================================================
`define REG_CMD 8'h00
`define REG_STATUS 8'h04
`define REG_FLAGS 8'h08

// ==========================================================================
// Field positions
// ==========================================================================
`define CMD_TARGET_LSB 0
`define CMD_AUTO_STOP 3
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ERR_REFUSED 2
`define ST_ERR_TIMEOUT 3
`define ST_ERR_UNSTABLE 4
`define ST_CUR_LSB 8
`define ST_SEL_LSB 16
`define FL_FAST_STOP 0
`define FL_MAIN_STOP 1
`define FL_SUB_STOP 2
`define FL_MAIN_MODE 4
`define FL_MAIN_EXT 5
`define FL_SUB_MODE 6
`define FL_SUB_EXT 7

// ==========================================================================
// Source codes
// ==========================================================================
`define SRC_FAST 3'h0
`define SRC_MAIN_XTAL 3'h1
`define SRC_MAIN_EXT 3'h2
`define SRC_SUB_XTAL 3'h3
`define SRC_SUB_EXT 3'h4

// ==========================================================================
// Reset values of the device flags
// ==========================================================================
`define RST_FAST_STOP 1'b0
`define RST_MAIN_STOP 1'b1
`define RST_SUB_STOP 1'b1

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_MHZ 100
`define T_XTAL_STAB_US 100
`define T_FAST_ACC_US 20
`define T_CONFIRM_US 5
`define XTAL_STAB_CYC (`T_XTAL_STAB_US * `CLK_MHZ)
`define FAST_ACC_CYC (`T_FAST_ACC_US * `CLK_MHZ)
`define CONFIRM_CYC (`T_CONFIRM_US * `CLK_MHZ)
`define TIMER_W 16

`endif

// *** verilog/wait_timer.v ***
// Down counter that signals when a loaded cycle count has run out.
// Assumes load is a single-cycle pulse from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "clk_switch_consts.vh"

module wait_timer (
  input wire mclk,
  input wire resetn,
  input wire load,
  input wire [`TIMER_W-1:0] count,
  output wire expired
);

  reg [`TIMER_W-1:0] cnt_q;
  reg run_q;

  // ========================================================================
  // Counter
  // ========================================================================
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= {`TIMER_W{1'b0}};
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      run_q <= 1'b1;
    end else if (run_q && cnt_q != {`TIMER_W{1'b0}}) begin
      cnt_q <= cnt_q - {{(`TIMER_W-1){1'b0}}, 1'b1};
    end
  end

  // Expired stays high from the end of a count until the next load.
  assign expired = run_q && !load && (cnt_q == {`TIMER_W{1'b0}});

endmodule
`default_nettype wire

// *** test/clk_switch_monitor.sv ***
// Checker for the clock switch controller, watching its device-side ports.
// Assumes the device reports a requested source within a few cycles.
`timescale 1ns/10ps
`default_nettype none
`include "clk_switch_consts.vh"
module clk_switch_monitor #(
  parameter XTAL_STAB_CYCLES = 10000
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] cur_src_pin,
  input wire logic [2:0] cpu_src_sel,
  input wire logic main_osc_mode_select,
  input wire logic main_external_input_select,
  input wire logic main_clock_stop,
  input wire logic sub_osc_mode_select,
  input wire logic sub_external_input_select,
  input wire logic sub_clock_stop,
  input wire logic onchip_fast_osc_stop
);
  logic [15:0] main_cnt_q;
  logic [15:0] sub_cnt_q;
  logic [15:0] fast_cnt_q;
  wire main_on = main_osc_mode_select & ~main_external_input_select & ~main_clock_stop;
  wire sub_on = sub_osc_mode_select & ~sub_external_input_select & ~sub_clock_stop;
  // ==========================================================================
  // Cycle counts for which each oscillator has run, saturating.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      main_cnt_q <= 16'h0;
      sub_cnt_q <= 16'h0;
      fast_cnt_q <= 16'hffff;
    end else begin
      main_cnt_q <= main_on ? main_cnt_q + {15'h0, ~&main_cnt_q} : 16'h0;
      sub_cnt_q <= sub_on ? sub_cnt_q + {15'h0, ~&sub_cnt_q} : 16'h0;
      fast_cnt_q <= !onchip_fast_osc_stop ? fast_cnt_q + {15'h0, ~&fast_cnt_q} : 16'h0;
    end
  end
  // ==========================================================================
  // Assertions.
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  main_cfg_a: assert property (
    cpu_src_sel == `SRC_MAIN_XTAL |-> main_on) else $error("main crystal not enabled");
  main_ext_cfg_a: assert property (
    cpu_src_sel == `SRC_MAIN_EXT |-> main_osc_mode_select && main_external_input_select
    && !main_clock_stop) else $error("external main input not enabled");
  sub_cfg_a: assert property (
    cpu_src_sel == `SRC_SUB_XTAL |-> sub_on) else $error("sub crystal not enabled");
  sub_ext_cfg_a: assert property (
    cpu_src_sel == `SRC_SUB_EXT |-> sub_osc_mode_select && sub_external_input_select
    && !sub_clock_stop) else $error("external sub input not enabled");
  main_wait_a: assert property (
    $changed(cpu_src_sel) && cpu_src_sel == `SRC_MAIN_XTAL |-> main_cnt_q >= XTAL_STAB_CYCLES - 1)
    else $error("main crystal chosen too early");
  sub_wait_a: assert property (
    $changed(cpu_src_sel) && cpu_src_sel == `SRC_SUB_XTAL |-> sub_cnt_q >= XTAL_STAB_CYCLES - 1)
    else $error("sub crystal chosen too early");
  fast_wait_a: assert property (
    $changed(cpu_src_sel) && cpu_src_sel == `SRC_FAST |-> !onchip_fast_osc_stop
    && fast_cnt_q >= `FAST_ACC_CYC - 1) else $error("fast oscillator chosen too early");
  fast_stop_a: assert property (
    $rose(onchip_fast_osc_stop) |-> cpu_src_sel != `SRC_FAST && $past(cur_src_pin, 2) == cpu_src_sel)
    else $error("fast oscillator stopped before confirm");
  main_stop_a: assert property (
    $rose(main_clock_stop) |-> (cpu_src_sel == 3'h0 || cpu_src_sel > 3'h2)
    && ($past(cur_src_pin, 2) == 3'h0 || $past(cur_src_pin, 2) > 3'h2))
    else $error("main clock stopped while in use");
endmodule
bind clk_switch_ctrl clk_switch_monitor #(.XTAL_STAB_CYCLES(XTAL_STAB_CYCLES)) u_clk_switch_monitor (
  .mclk, .resetn, .cur_src_pin, .cpu_src_sel, .main_osc_mode_select, .main_external_input_select,
  .main_clock_stop, .sub_osc_mode_select, .sub_external_input_select, .sub_clock_stop,
  .onchip_fast_osc_stop);
`default_nettype wire

// *** test/clk_device_model.sv ***
// Model of the clocked device: oscillators, stability and the source report.
// Assumes the bench may slow the crystals or freeze the report on purpose.
`timescale 1ns/10ps
`default_nettype none
module clk_device_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] cpu_src_sel,
  input wire logic main_osc_mode_select,
  input wire logic main_external_input_select,
  input wire logic main_clock_stop,
  input wire logic sub_osc_mode_select,
  input wire logic sub_external_input_select,
  input wire logic sub_clock_stop,
  input wire logic onchip_fast_osc_stop,
  input wire logic slow_osc,
  input wire logic stuck,
  output logic [2:0] cur_src_pin,
  output logic main_osc_stable,
  output logic sub_osc_stable
);
  logic [7:0] main_cnt_q;
  logic [7:0] sub_cnt_q;
  logic [1:0] lag_q;
  wire [7:0] thr = slow_osc ? 8'hc8 : 8'h0a;
  wire main_x = main_osc_mode_select & ~main_external_input_select & ~main_clock_stop;
  wire main_e = main_osc_mode_select & main_external_input_select & ~main_clock_stop;
  wire sub_x = sub_osc_mode_select & ~sub_external_input_select & ~sub_clock_stop;
  wire sub_e = sub_osc_mode_select & sub_external_input_select & ~sub_clock_stop;
  wire direct = cur_src_pin inside {3'h1, 3'h2} && cpu_src_sel inside {3'h1, 3'h2};
  assign main_osc_stable = main_cnt_q >= thr;
  assign sub_osc_stable = sub_cnt_q >= thr;
  function automatic logic src_on(input logic [2:0] s);
    case (s)
      3'h0: src_on = !onchip_fast_osc_stop;
      3'h1: src_on = main_x && main_osc_stable;
      3'h2: src_on = main_e;
      3'h3: src_on = sub_x && sub_osc_stable;
      3'h4: src_on = sub_e;
      default: src_on = 1'b0;
    endcase
  endfunction
  // ==========================================================================
  // The report follows a usable request three cycles later.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      main_cnt_q <= 8'h0;
      sub_cnt_q <= 8'h0;
      lag_q <= 2'h0;
      cur_src_pin <= 3'h0;
    end else begin
      main_cnt_q <= main_x ? main_cnt_q + {7'h0, ~&main_cnt_q} : 8'h0;
      sub_cnt_q <= sub_x ? sub_cnt_q + {7'h0, ~&sub_cnt_q} : 8'h0;
      if (cpu_src_sel != cur_src_pin && src_on(cpu_src_sel) && !stuck && !direct) begin
        lag_q <= lag_q + 2'h1;
        if (lag_q == 2'h2) cur_src_pin <= cpu_src_sel;
      end else lag_q <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// *** test/cpu_clock_source_switch_tb.sv ***
// Self-checking bench for the clock switch controller with a device model.
// Assumes the checker is bound to the controller by its own file.
`timescale 1ns/10ps
`default_nettype none
`include "clk_switch_consts.vh"
module cpu_clock_source_switch_tb;
  logic mclk, resetn, wr_stb, rd_stb, slow_osc, stuck, main_osc_stable, sub_osc_stable;
  logic main_osc_mode_select, main_external_input_select, main_clock_stop, hold_old;
  logic sub_osc_mode_select, sub_external_input_select, sub_clock_stop, onchip_fast_osc_stop;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, s, f;
  logic [2:0] cur_src_pin, cpu_src_sel, cur;
  int failures, n_checks;
  clk_switch_ctrl #(.XTAL_STAB_CYCLES(20)) u_clk_switch_ctrl (.mclk, .resetn, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .cur_src_pin, .main_osc_stable, .sub_osc_stable, .cpu_src_sel,
    .main_osc_mode_select, .main_external_input_select, .main_clock_stop, .sub_osc_mode_select,
    .sub_external_input_select, .sub_clock_stop, .onchip_fast_osc_stop);
  clk_device_model u_clk_device_model (.mclk, .resetn, .cpu_src_sel, .main_osc_mode_select,
    .main_external_input_select, .main_clock_stop, .sub_osc_mode_select,
    .sub_external_input_select, .sub_clock_stop, .onchip_fast_osc_stop, .slow_osc, .stuck,
    .cur_src_pin, .main_osc_stable, .sub_osc_stable);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================================
  // Bus cycles, comparison and expectations.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [31:0] cfg_val(input logic [2:0] t);
    cfg_val = t == 3'h1 ? 32'h10 : t == 3'h2 ? 32'h30 : t == 3'h3 ? 32'h40 : t == 3'h4 ? 32'hc0 : 0;
  endfunction
  function automatic logic [31:0] fam(input logic [2:0] t, input logic [31:0] a, b, c);
    fam = t == 3'h0 ? a : t < 3'h3 ? b : c;
  endfunction
  // Issues a command and checks the status code and, when it succeeds, the flags.
  task step(input logic [2:0] t, input logic [4:0] code);
    logic [2:0] n;
    logic [31:0] m;
    int i;
    n = code[1] ? t : cur;
    m = fam(cur, 1, 2, 4);
    repeat ($urandom % 4) @(posedge mclk);
    wr(`REG_CMD, {28'h0, !hold_old, t});
    if (code == 5'h6) wr(`REG_CMD, {28'h0, 1'b1, 3'h0});
    rd(`REG_STATUS, s);
    for (i = 0; s[0] !== 1'b0 && i < 3000; i++) rd(`REG_STATUS, s);
    if (code == 5'h8) chk(s & 32'h1f, 32'h8);
    else chk(s & 32'h7071f, {13'h0, n, 5'h0, n, 3'h0, code});
    if (code[1]) begin
      rd(`REG_FLAGS, f);
      chk(f & (fam(t, 1, 32'h32, 32'hc4) | m), cfg_val(t) | (hold_old ? 32'h0 : m));
    end
    cur = n;
  endtask
  task results;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    {resetn, wr_stb, rd_stb, slow_osc, stuck, hold_old, addr, wdata, cur, failures, n_checks} = 0;
    s = $urandom(73);
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(`REG_FLAGS, f);
    chk(f, 32'h6);
    rd(`REG_STATUS, s);
    chk(s, 32'h0);
    rd(8'h0c + 8'(($urandom % 60) * 4), s);
    chk(s, 32'h0);
    slow_osc <= 1'b1;
    step(3'h1, 5'h10);
    slow_osc <= 1'b0;
    step(3'h1, 5'h2);
    step(3'h2, 5'h4);
    step(3'h0, 5'h2);
    step(3'h2, 5'h2);
    step(3'h1, 5'h4);
    step(3'h3, 5'h2);
    step(3'h0, 5'h6);
    step(3'h4, 5'h2);
    step(3'h0, 5'h2);
    step(3'h5 + 3'($urandom % 3), 5'h4);
    stuck <= 1'b1;
    step(3'h3, 5'h8);
    @(posedge mclk);
    resetn <= 1'b0;
    stuck <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    cur = 3'h0;
    rd(`REG_FLAGS, f);
    chk(f, 32'h6);
    hold_old = 1'b1;
    step(3'h2, 5'h2);
    wr(`REG_FLAGS, 32'h7);
    rd(`REG_FLAGS, f);
    chk(f, 32'h35);
    results();
  end
  initial begin
    #500000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
